// file: rtl/usb_ctl.sv
// usb control and error-enable register block with apb slave
`timescale 1ns/100ps
`default_nettype none
module usb_ctl (
	input wire logic pclk, // apb clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic [usb_ctl_pkg::ERR_W-1:0] err_event, // error event pulses
	input wire usb_ctl_pkg::link_in_type link_in, // line and system state
	output usb_ctl_pkg::link_out_type link_out // control outputs
);
	import usb_ctl_pkg::*;

	// ==========================================
	// state
	typedef struct packed {
		logic [7:0] err_en;
		logic [7:0] err_flags;
		logic [7:0] ctl;
		logic [7:0] cfg;
		logic [7:0] irq_en;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic [3:0] eop_cnt;
		logic [1:0] hrst_cnt;
		link_out_type out;
	} state_type;

	state_type s_q, s_d;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	logic setup_phase;
	logic host;
	logic [7:0] ctl_rd;
	logic [7:0] err_masked;
	assign setup_phase = psel && !penable;
	assign host = s_q.ctl[CTL_HOST_POS];

	// ==========================================
	// next-state logic
	always_comb begin
		s_d = s_q;
		s_d.ready = 1'b0;
		s_d.slverr = 1'b0;
		// live line flags, busy indicator in host mode
		ctl_rd = s_q.ctl;
		ctl_rd[CTL_IDLE_DIFFERENTIAL_FLAG_POS] = link_in.j_state;
		ctl_rd[CTL_SE0_POS] = link_in.se0;
		if (host) begin
			ctl_rd[CTL_PACKET_PROCESSING_DISABLE_POS] = link_in.token_active;
		end
		// hardware records every error regardless of enable
		s_d.err_flags = s_q.err_flags | err_event;
		// apb access, answered one cycle after setup
		if (setup_phase) begin
			s_d.ready = 1'b1;
			s_d.rdata = 32'h0000_0000;
			if (pwrite) begin
				if (hit(paddr, OFS_ERR_EN)) begin
					s_d.err_en = pwdata[7:0];
				end else if (hit(paddr, OFS_CONTROL)) begin
					s_d.ctl = (s_q.ctl & ~CTL_WMASK) | (pwdata[7:0] & CTL_WMASK);
				end else if (hit(paddr, OFS_CONFIG)) begin
					s_d.cfg = pwdata[7:0] & CFG_WMASK;
				end else if (hit(paddr, OFS_ERR_FLAGS)) begin
					// write one to clear; a new event in the same cycle wins
					s_d.err_flags = (s_q.err_flags & ~pwdata[7:0]) | err_event;
				end else if (hit(paddr, OFS_IRQ_EN)) begin
					s_d.irq_en = pwdata[7:0];
				end else if (!hit(paddr, OFS_STATUS)) begin
					s_d.slverr = 1'b1;
				end
			end else begin
				if (hit(paddr, OFS_ERR_EN)) begin
					s_d.rdata[7:0] = s_q.err_en;
				end else if (hit(paddr, OFS_CONTROL)) begin
					s_d.rdata[7:0] = ctl_rd;
				end else if (hit(paddr, OFS_CONFIG)) begin
					s_d.rdata[7:0] = s_q.cfg;
				end else if (hit(paddr, OFS_ERR_FLAGS)) begin
					s_d.rdata[7:0] = s_q.err_flags;
				end else if (hit(paddr, OFS_IRQ_EN)) begin
					s_d.rdata[7:0] = s_q.irq_en;
				end else if (hit(paddr, OFS_STATUS)) begin
					s_d.rdata[7:0] = {6'h00, s_q.out.suspended, s_q.out.halted};
				end else begin
					s_d.slverr = 1'b1;
				end
			end
		end
		// setup token latches the disable in device mode; host ignores it
		if (!host && link_in.setup_seen) begin
			s_d.ctl[CTL_PACKET_PROCESSING_DISABLE_POS] = 1'b1;
		end
		// any toggle of host enable restarts host logic
		if (s_d.ctl[CTL_HOST_POS] != s_q.ctl[CTL_HOST_POS]) begin
			s_d.hrst_cnt = 2'(HRST_CYC);
		end else if (s_q.hrst_cnt != 2'h0) begin
			s_d.hrst_cnt = s_q.hrst_cnt - 2'h1;
		end
		// falling resume in host mode arms the low-speed eop
		if (host && s_q.ctl[CTL_RESUME_POS] && !s_d.ctl[CTL_RESUME_POS]) begin
			s_d.eop_cnt = 4'(LS_EOP_CYC);
		end else if (s_q.eop_cnt != 4'h0) begin
			s_d.eop_cnt = s_q.eop_cnt - 4'h1;
		end
		// enabled error mask; bit 1 is crc5 in device, eof in host, same flag line
		err_masked = s_q.err_flags & s_q.err_en;
		s_d.out.module_irq_flag = (|err_masked) && s_q.irq_en[IRQEN_ERR_POS];
		s_d.out.bus_reset_drive = s_d.ctl[CTL_BUSRST_POS];
		s_d.out.resume_drive = s_d.ctl[CTL_RESUME_POS];
		s_d.out.eop_drive = (s_d.eop_cnt != 4'h0);
		s_d.out.eye_pattern = s_d.cfg[CFG_EYE_POS];
		s_d.out.oe_monitor_n = !(s_d.cfg[CFG_OEMON_POS] && link_in.drive_active);
		s_d.out.host_logic_rst = (s_d.hrst_cnt != 2'h0);
		s_d.out.packet_processing_disable = !host && s_d.ctl[CTL_PACKET_PROCESSING_DISABLE_POS];
		s_d.out.halted = s_d.cfg[CFG_SIDL_POS] && link_in.idle_mode;
		// auto suspend in sleep, else only the manual power-control bit
		s_d.out.suspended = (s_d.cfg[CFG_ASUSP_POS] && link_in.sleep_mode)
			|| link_in.manual_suspend;
	end

	// ==========================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.err_en <= ERR_EN_RST;
			s_q.ctl <= CTL_RST;
			s_q.cfg <= CFG_RST;
			s_q.out.oe_monitor_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.slverr;
	assign link_out = s_q.out;

	// ==========================================
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	irq_gate_a: assert property (s_q.out.module_irq_flag |-> $past(s_q.irq_en[IRQEN_ERR_POS]))
		else $error("irq without master enable");
	irq_mask_a: assert property (s_q.out.module_irq_flag |-> $past(|(s_q.err_flags & s_q.err_en)))
		else $error("irq without enabled flag");
	flag_keep_a: assert property (err_event[PID_POS] |=> s_q.err_flags[PID_POS])
		else $error("error event lost");
	packet_processing_disable_set_a: assert property (!host && link_in.setup_seen |=> s_q.ctl[CTL_PACKET_PROCESSING_DISABLE_POS])
		else $error("setup did not disable packets");
	busrst_a: assert property (s_q.out.bus_reset_drive == $past(s_d.ctl[CTL_BUSRST_POS]))
		else $error("bus reset drive mismatch");
	hostrst_a: assert property ($changed(s_q.ctl[CTL_HOST_POS]) |-> s_q.out.host_logic_rst)
		else $error("host toggle without host reset");
	resume_a: assert property ($rose(s_q.ctl[CTL_RESUME_POS]) |=> s_q.out.resume_drive)
		else $error("resume not driven");
	eop_a: assert property (host && $fell(s_q.ctl[CTL_RESUME_POS]) |-> s_q.out.eop_drive [*8])
		else $error("low-speed eop too short");
	eye_a: assert property ($rose(s_q.cfg[CFG_EYE_POS]) |-> s_q.out.eye_pattern)
		else $error("eye pattern not enabled");
	rd_hi_a: assert property (s_q.ready |-> s_q.rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	apb_ready_a: assert property (psel && !penable |=> pready)
		else $error("apb not answered");

	read_cov_c: cover property (psel && penable && pready && !pwrite);
	irq_cov_c: cover property ($rose(s_q.out.module_irq_flag));
	eop_cov_c: cover property ($rose(s_q.out.eop_drive));
	hrst_cov_c: cover property ($rose(s_q.out.host_logic_rst));
endmodule // usb_ctl
`default_nettype wire

// file: rtl/usb_ctl_pkg.sv
// package: register map, field positions and carrier types for the usb control block
package usb_ctl_pkg;
	// register byte offsets (no offsets printed; chosen here)
	localparam logic [7:0] OFS_ERR_EN = 8'h00;
	localparam logic [7:0] OFS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_CONFIG = 8'h08;
	localparam logic [7:0] OFS_ERR_FLAGS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_EN = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	// error enable field positions
	localparam int BIT_STUFF_POS = 7;
	localparam int PID_POS = 0;
	localparam int ERR_W = 8;
	// control field positions
	localparam int CTL_IDLE_DIFFERENTIAL_FLAG_POS = 7;
	localparam int CTL_SE0_POS = 6;
	localparam int CTL_PACKET_PROCESSING_DISABLE_POS = 5;
	localparam int CTL_BUSRST_POS = 4;
	localparam int CTL_HOST_POS = 3;
	localparam int CTL_RESUME_POS = 2;
	// configuration field positions
	localparam int CFG_EYE_POS = 7;
	localparam int CFG_OEMON_POS = 6;
	localparam int CFG_SIDL_POS = 4;
	localparam int CFG_ASUSP_POS = 0;
	localparam logic [7:0] CFG_WMASK = 8'hD1;
	localparam logic [7:0] CTL_WMASK = 8'h3C;
	// module interrupt enable field
	localparam int IRQEN_ERR_POS = 1;
	// reset values
	localparam logic [7:0] ERR_EN_RST = 8'h00;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	// low-speed end of packet: two bit times of SE0 at 1.5 Mbit/s, about 1333 ns
	localparam int LS_EOP_NS = 1333;
	localparam int CLK_NS = 100;
	localparam int LS_EOP_CYC = (LS_EOP_NS + CLK_NS - 1) / CLK_NS;
	localparam int HRST_CYC = 2;

	typedef struct packed {
		logic j_state; // line in j state
		logic se0; // single-ended zero
		logic drive_active; // transceiver drives d+/d-
		logic setup_seen; // setup token received (pulse)
		logic token_active; // host token executing
		logic idle_mode; // system in idle
		logic sleep_mode; // system in sleep
		logic manual_suspend; // power control suspend bit
	} link_in_type;

	typedef struct packed {
		logic bus_reset_drive; // drive usb reset
		logic resume_drive; // drive resume k state
		logic eop_drive; // drive low-speed eop
		logic eye_pattern; // eye test output
		logic oe_monitor_n; // active-low oe monitor
		logic host_logic_rst; // host logic reset pulse
		logic packet_processing_disable; // token processing held
		logic halted; // module stopped
		logic suspended; // module suspended
		logic module_irq_flag; // usb interrupt request
	} link_out_type;
endpackage

// file: test/usb_far_end.sv
// far-end model: line states seen by the block's receiver
`timescale 1ns/100ps
`default_nettype none
module usb_far_end (
	input wire logic pclk, // bus clock
	input wire logic [1:0] state_sel, // 1 j, 2 se0, else k
	output logic j_state, // j state on the lines
	output logic se0 // single-ended zero on the lines
);
	// lines change on the clock only, like a synchronised receiver
	always_ff @(posedge pclk) begin
		j_state <= (state_sel == 2'h1);
		se0 <= (state_sel == 2'h2);
	end
endmodule // usb_far_end
`default_nettype wire

// file: test/usb_ctl_tb_top.sv
// self-checking bench for the usb control block
`timescale 1ns/100ps
`default_nettype none
module usb_ctl_tb_top;
	import usb_ctl_pkg::*;
	// ==========
	// signals
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, j, s0;
	logic serr = 0;
	logic [31:0] rnd = 32'h0;
	logic drv = 0, setup = 0, tok = 0, idle = 0, slp = 0, msusp = 0;
	logic [7:0] paddr = 8'h00, err = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, d, seed = 32'h0000912A;
	logic [1:0] sel = 2'h0;
	link_in_type li;
	link_out_type lo;
	int errors = 0, n_checks = 0, hrst = 0, eop = 0;
	assign li = '{j, s0, drv, setup, tok, idle, slp, msusp};
	always #50 pclk = ~pclk;
	// pulse lengths are counted, since they end before a read could see them
	always @(posedge pclk) begin
		hrst += (lo.host_logic_rst === 1'b1);
		eop += (lo.eop_drive === 1'b1);
	end
	usb_far_end far (.pclk(pclk), .state_sel(sel), .j_state(j), .se0(s0));
	usb_ctl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .err_event(err), .link_in(li), .link_out(lo));
	// ==========
	// helpers
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [7:0] wmask(input int a);
		return (a == 0) ? 8'hFF : 8'hD1;
	endfunction
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// apb transfer, holds the request until pready is sampled high at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		// only the watchdog ends a wait that never sees ready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		d = prdata;
		serr = pslverr;
		psel <= 0;
		penable <= 0;
		// one idle edge so the next call never re-drives psel in this step
		@(posedge pclk);
	endtask
	task pulse(input int b);
		err <= 8'h01 << b;
		@(posedge pclk);
		err <= 8'h00;
		repeat (4) @(posedge pclk);
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		errors++;
		end_sim();
	end
	// ==========
	// tests
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		for (int i = 0; i < 5; i++) begin
			apb(0, 8'(4 * i), 0);
			chk("reset value", d, 0);
		end
		for (int i = 0; i < 12; i++) begin
			rnd = xs();
			apb(1, 8'((i % 2) * 8), rnd);
			apb(0, 8'((i % 2) * 8), 0);
			chk("readback", d, {24'h0, rnd[7:0] & wmask((i % 2) * 8)});
		end
		$display("test 1 done");
		apb(1, 8'h10, 32'h2);
		for (int b = 0; b < 8; b++) begin
			apb(1, 8'h00, 32'h1 << b);
			pulse(b);
			chk("irq on", lo.module_irq_flag, 1);
			apb(1, 8'h0C, 32'hFF);
			apb(1, 8'h00, ~(32'h1 << b) & 32'hFF);
			pulse(b);
			chk("irq masked", lo.module_irq_flag, 0);
			apb(0, 8'h0C, 0);
			chk("flag kept", d, 32'h1 << b);
			apb(1, 8'h0C, 32'hFF);
		end
		apb(1, 8'h00, 32'hFF);
		apb(1, 8'h10, 0);
		pulse(7);
		chk("master off", lo.module_irq_flag, 0);
		$display("test 2 done");
		for (int k = 0; k < 3; k++) begin
			sel <= 2'(k);
			repeat (3) @(posedge pclk);
			apb(0, 8'h04, 0);
			chk("live lines", d[7:6], {k == 1, k == 2});
		end
		setup <= 1;
		@(posedge pclk);
		setup <= 0;
		repeat (2) @(posedge pclk);
		chk("pkt disable", lo.packet_processing_disable, 1);
		apb(1, 8'h04, 32'h14);
		chk("pkt enable", lo.packet_processing_disable, 0);
		chk("bus reset", {lo.bus_reset_drive, lo.resume_drive}, 2'b11);
		apb(1, 8'h04, 0);
		chk("lines free", {lo.bus_reset_drive, lo.resume_drive, 6'(eop)}, 0);
		tok <= 1;
		apb(1, 8'h04, 32'h0C);
		apb(0, 8'h04, 0);
		chk("token busy", d[5], 1);
		tok <= 0;
		// resume hold shortened from the ms span to keep the run short
		apb(1, 8'h04, 32'h08);
		repeat (LS_EOP_CYC + 2) @(posedge pclk);
		chk("eop length", eop, LS_EOP_CYC);
		apb(0, 8'h04, 0);
		chk("token idle", d[5], 0);
		apb(1, 8'h04, 0);
		repeat (3) @(posedge pclk);
		chk("host reset", hrst, 2 * HRST_CYC);
		$display("test 3 done");
		apb(1, 8'h08, 32'hD1);
		drv <= 1;
		idle <= 1;
		slp <= 1;
		repeat (3) @(posedge pclk);
		chk("cfg on", {lo.eye_pattern, lo.oe_monitor_n, lo.halted, lo.suspended}, 4'hB);
		apb(1, 8'h08, 0);
		chk("cfg off", {lo.eye_pattern, lo.oe_monitor_n, lo.halted, lo.suspended}, 4'h4);
		msusp <= 1;
		repeat (2) @(posedge pclk);
		chk("manual suspend", lo.suspended, 1);
		apb(0, 8'h20, 0);
		chk("unmapped", {serr, d}, 33'h100000000);
		$display("test 4 done");
		end_sim();
	end
endmodule // usb_ctl_tb_top
`default_nettype wire
